/* inc/sapu_defs.svh */
// Register offsets, field positions, reset values and fixed figures of the address unit.
`ifndef SAPU_DEFS_SVH
`define SAPU_DEFS_SVH
`define SAPU_OFF_CTRL 8'h00
`define SAPU_OFF_SEG 8'h04
`define SAPU_OFF_OFFS 8'h08
`define SAPU_OFF_SEL 8'h0C
`define SAPU_OFF_ACCR 8'h10
`define SAPU_OFF_SP 8'h14
`define SAPU_OFF_TLIM 8'h18
`define SAPU_OFF_PFRM 8'h1C
`define SAPU_OFF_CMD 8'h20
`define SAPU_OFF_CS 8'h24
`define SAPU_OFF_PHYS 8'h28
`define SAPU_OFF_STAT 8'h2C
`define SAPU_OFF_RET 8'h30
`define SAPU_OFF_BASE0 8'h40
`define SAPU_BIT_PROT 0
`define SAPU_BIT_PAGE 1
`define SAPU_BIT_IF 2
`define SAPU_BIT_STACK 3
`define SAPU_BIT_FETCH 4
`define SAPU_BIT_CONF 5
`define SAPU_CMD_ACCESS 0
`define SAPU_CMD_HALT 1
`define SAPU_CMD_FARJMP 2
`define SAPU_CMD_PUSH 3
`define SAPU_CMD_INT 4
`define SAPU_SEG_LAST 17'h0FFFF
`define SAPU_NMI_TLIM 16'h0017
`define SAPU_NMI_SP 16'h0005
`define SAPU_FLT_DBL 5'h08
`define SAPU_FLT_STK 5'h0C
`define SAPU_FLT_GP 5'h0D
`define SAPU_CTRL_RST 8'h00
`define SAPU_TLIM_RST 16'h03FF
`define SAPU_NBASE 8
`endif

/* inc/sapu_pkg.sv */
// Types shared by the address and privilege unit.
package sapu_pkg;
   typedef enum logic [1:0] {RUN, HALTED, SHUTDOWN} sapu_state_e;
   typedef logic [1:0] sapu_priv_t;
endpackage

/* rtl/sapu_core.sv */
// Address formation, segment checks, halt and shutdown, privilege arithmetic.
`timescale 1ns/1ps
`default_nettype none
`include "sapu_defs.svh"
module sapu_core (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   input wire logic nmiPin,
   input wire logic maskableIrq,
   output logic busActive,
   output logic shutdownCycle
);
   logic ack_q;
   logic [31:0] rdat_q;
   logic [7:0] ctrl_q;
   logic [15:0] seg_q;
   logic [31:0] offs_q;
   logic [15:0] sel_q;
   logic [7:0] accr_q;
   logic [15:0] stackPointer_q;
   logic [15:0] tlim_q;
   logic [19:0] pfrm_q;
   logic [15:0] cs_q;
   logic [31:0] phys_q;
   logic [31:0] ret_q;
   logic [4:0] fault_q;
   logic faultValid_q;
   logic highAddr_q;
   logic busActive_q;
   logic shut_q;
   sapu_pkg::sapu_priv_t currentPriv_q;
   sapu_pkg::sapu_state_e state_q;
   sapu_pkg::sapu_state_e state_d;
   logic [31:0] base_q [`SAPU_NBASE];
   logic [2:0] nmiSync_q;
   logic [2:0] irqSync_q;
   logic nmiLvl_q;
   logic irqLvl_q;
   logic nmiPrev_q;

   // Bus decode.
   wire busReq = wbCyc && wbStb && !ack_q;
   wire wrEn = busReq && wbWe;
   wire [31:0] wmask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
   wire wrCtrl = wrEn && wbAdr == `SAPU_OFF_CTRL;
   wire wrSeg = wrEn && wbAdr == `SAPU_OFF_SEG;
   wire wrOffs = wrEn && wbAdr == `SAPU_OFF_OFFS;
   wire wrSel = wrEn && wbAdr == `SAPU_OFF_SEL;
   wire wrAccr = wrEn && wbAdr == `SAPU_OFF_ACCR;
   wire wrSp = wrEn && wbAdr == `SAPU_OFF_SP;
   wire wrTlim = wrEn && wbAdr == `SAPU_OFF_TLIM;
   wire wrPfrm = wrEn && wbAdr == `SAPU_OFF_PFRM;
   wire wrCs = wrEn && wbAdr == `SAPU_OFF_CS;
   wire wrCmd = wrEn && wbAdr == `SAPU_OFF_CMD;
   wire isBase = wbAdr[7:5] == 3'h2;
   wire [31:0] wdat = wbDatI & wmask;
   wire [31:0] cmd = wrCmd ? wdat : 32'h0000_0000;
   wire running = state_q == sapu_pkg::RUN;
   wire cmdAccess = cmd[`SAPU_CMD_ACCESS] && running;
   wire cmdHalt = cmd[`SAPU_CMD_HALT] && running;
   wire cmdFar = cmd[`SAPU_CMD_FARJMP] && running;
   wire cmdPush = cmd[`SAPU_CMD_PUSH] && running;
   wire cmdInt = cmd[`SAPU_CMD_INT] && running;
   wire [7:0] vector = cmd[15:8];
   wire [1:0] accWidth = cmd[17:16];

   // Mode bits.
   wire protMode = ctrl_q[`SAPU_BIT_PROT];
   wire pageEn = protMode && ctrl_q[`SAPU_BIT_PAGE];
   wire intFlag = ctrl_q[`SAPU_BIT_IF];
   wire stackRef = ctrl_q[`SAPU_BIT_STACK];
   wire codeFetch = ctrl_q[`SAPU_BIT_FETCH];

   // Segmented address: the sum can carry into bit 20, the top being 10FFEFH.
   wire [20:0] realSum = {1'b0, seg_q, 4'h0} + {5'h00, offs_q[15:0]};
   wire [11:0] realHigh = (highAddr_q && codeFetch) ? 12'hFFF : {11'h000, realSum[20]};
   wire [31:0] realPhys = {realHigh, realSum[19:0]};

   // Protected address: index bits of the selector pick a four-byte base entry.
   wire [2:0] baseIdx = sel_q[5:3];
   wire [31:0] linear = base_q[baseIdx] + offs_q;
   wire [31:0] protPhys = pageEn ? {pfrm_q, linear[11:0]} : linear;
   wire [31:0] accPhys = protMode ? protPhys : realPhys;

   // Segment overrun: only the 64K limit is checked, never the rights byte.
   wire [16:0] lastByte = {1'b0, offs_q[15:0]} + {15'h0000, accWidth};
   wire overrun = !protMode && (offs_q[31:16] != 16'h0000 || lastByte > `SAPU_SEG_LAST);
   wire [4:0] overCode = stackRef ? `SAPU_FLT_STK : `SAPU_FLT_GP;

   // Vector table: entry n at byte 4n, handler present when its last byte fits.
   wire [17:0] vecLast = {8'h00, vector, 2'b11};
   wire vecOut = vecLast > {2'b00, tlim_q};
   wire [17:0] dblLast = {11'h000, `SAPU_FLT_DBL, 2'b11};
   wire [17:0] gpLast = {11'h000, `SAPU_FLT_GP, 2'b11};
   wire noDblHandler = dblLast > {2'b00, tlim_q};
   wire noGpHandler = gpLast > {2'b00, tlim_q};
   wire accShut = cmdAccess && overrun && !stackRef && noGpHandler;
   wire intShut = cmdInt && vecOut && noDblHandler;
   wire stackWrap = cmdPush && stackPointer_q[0] && stackPointer_q[15:1] == 15'h0000;
   wire enterShut = accShut || intShut || stackWrap;

   // Wake conditions.
   wire nmiRise = nmiLvl_q && !nmiPrev_q;
   wire nmiOk = tlim_q >= `SAPU_NMI_TLIM && stackPointer_q > `SAPU_NMI_SP;
   wire haltWake = nmiRise || (irqLvl_q && intFlag);

   // Privileges.
   wire [1:0] reqPriv = sel_q[1:0];
   wire [1:0] descPriv = accr_q[6:5];
   wire [1:0] effPriv = (reqPriv > descPriv) ? reqPriv : descPriv;
   wire [31:0] status = {8'h00, effPriv, currentPriv_q, descPriv, reqPriv, 2'b00,
                         faultValid_q, fault_q, 3'h0, highAddr_q, 2'b00, state_q};

   wire [31:0] baseRd = base_q[wbAdr[4:2]];
   wire [31:0] rdMux =
      wbAdr == `SAPU_OFF_CTRL ? {24'h000000, ctrl_q} :
      wbAdr == `SAPU_OFF_SEG ? {16'h0000, seg_q} :
      wbAdr == `SAPU_OFF_OFFS ? offs_q :
      wbAdr == `SAPU_OFF_SEL ? {16'h0000, sel_q} :
      wbAdr == `SAPU_OFF_ACCR ? {24'h000000, accr_q} :
      wbAdr == `SAPU_OFF_SP ? {16'h0000, stackPointer_q} :
      wbAdr == `SAPU_OFF_TLIM ? {16'h0000, tlim_q} :
      wbAdr == `SAPU_OFF_PFRM ? {12'h000, pfrm_q} :
      wbAdr == `SAPU_OFF_CS ? {16'h0000, cs_q} :
      wbAdr == `SAPU_OFF_PHYS ? phys_q :
      wbAdr == `SAPU_OFF_STAT ? status :
      wbAdr == `SAPU_OFF_RET ? ret_q :
      isBase ? baseRd : 32'h0000_0000;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         sapu_pkg::RUN:
         begin
            if (enterShut)
               state_d = sapu_pkg::SHUTDOWN;
            else if (cmdHalt)
               state_d = sapu_pkg::HALTED;
         end
         sapu_pkg::HALTED:
         begin
            if (haltWake)
               state_d = sapu_pkg::RUN;
         end
         sapu_pkg::SHUTDOWN:
         begin
            if (nmiRise && nmiOk)
               state_d = sapu_pkg::RUN;
         end
         default: state_d = sapu_pkg::RUN;
      endcase
   end

   // Three-stage pin synchronisers; a level counts once stages two and three agree.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         nmiSync_q <= 3'h0;
         irqSync_q <= 3'h0;
         nmiLvl_q <= 1'b0;
         irqLvl_q <= 1'b0;
         nmiPrev_q <= 1'b0;
      end
      else
      begin
         nmiSync_q <= {nmiSync_q[1:0], nmiPin};
         irqSync_q <= {irqSync_q[1:0], maskableIrq};
         if (nmiSync_q[1] == nmiSync_q[2])
            nmiLvl_q <= nmiSync_q[2];
         if (irqSync_q[1] == irqSync_q[2])
            irqLvl_q <= irqSync_q[2];
         nmiPrev_q <= nmiLvl_q;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= busReq;
         rdat_q <= busReq ? rdMux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_q <= `SAPU_CTRL_RST;
         seg_q <= 16'h0000;
         offs_q <= 32'h0000_0000;
         sel_q <= 16'h0000;
         accr_q <= 8'h00;
         stackPointer_q <= 16'h0000;
         tlim_q <= `SAPU_TLIM_RST;
         pfrm_q <= 20'h00000;
         cs_q <= 16'h0000;
         currentPriv_q <= 2'h0;
      end
      else
      begin
         if (wrCtrl)
            ctrl_q <= wdat[7:0];
         if (wrSeg)
            seg_q <= wdat[15:0];
         if (wrOffs)
            offs_q <= wdat;
         if (wrSel)
            sel_q <= wdat[15:0];
         if (wrAccr)
            accr_q <= wdat[7:0];
         if (wrSp)
            stackPointer_q <= wdat[15:0];
         if (wrTlim)
            tlim_q <= wdat[15:0];
         if (wrPfrm)
            pfrm_q <= wdat[19:0];
         if (wrCs)
            cs_q <= wdat[15:0];
         // A conforming code segment keeps the caller's level.
         if (wrCs && !ctrl_q[`SAPU_BIT_CONF])
            currentPriv_q <= wdat[1:0];
      end
   end

   for (genvar i = 0; i < `SAPU_NBASE; i++)
   begin : gBase
      always_ff @(posedge clk or negedge resetn)
      begin
         if (!resetn)
            base_q[i] <= 32'h0000_0000;
         else if (wrEn && isBase && wbAdr[4:2] == 3'(i))
            base_q[i] <= wdat;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= sapu_pkg::RUN;
         highAddr_q <= 1'b1;
         phys_q <= 32'h0000_0000;
         ret_q <= 32'h0000_0000;
         fault_q <= 5'h00;
         faultValid_q <= 1'b0;
         busActive_q <= 1'b1;
         shut_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         busActive_q <= state_d == sapu_pkg::RUN;
         // A refused NMI in shutdown repeats the shutdown cycle.
         shut_q <= enterShut || (state_q == sapu_pkg::SHUTDOWN && nmiRise && !nmiOk);
         if (cmdFar)
            highAddr_q <= 1'b0;
         if (cmdAccess)
         begin
            phys_q <= accPhys;
            faultValid_q <= overrun;
            fault_q <= overrun ? overCode : 5'h00;
            ret_q <= offs_q;
         end
         else if (cmdInt)
         begin
            phys_q <= {14'h0000, vecLast[17:2], 2'b00};
            faultValid_q <= vecOut;
            fault_q <= vecOut ? `SAPU_FLT_DBL : 5'h00;
            ret_q <= offs_q;
         end
         else if (cmdHalt)
            ret_q <= offs_q + 32'h0000_0001;
      end
   end

   assign wbAck = ack_q;
   assign wbDatO = rdat_q;
   assign busActive = busActive_q;
   assign shutdownCycle = shut_q;

   sequence haltTaken_s;
      cmdHalt && !enterShut;
   endsequence
   sequence haltHeld_s;
      state_q == sapu_pkg::HALTED;
   endsequence

   realAddr_a: assert property (@(posedge clk) disable iff (!resetn)
      cmdAccess && !protMode |=> phys_q[19:0] == $past(realSum[19:0]))
      else $error("segmented address wrong");
   overrun13_a: assert property (@(posedge clk) disable iff (!resetn)
      cmdAccess && !protMode && !stackRef && offs_q == 32'h0000_FFFF && accWidth == 2'h1
      |=> faultValid_q && fault_q == 5'h0D)
      else $error("word at FFFFH not faulted");
   stackFault_a: assert property (@(posedge clk) disable iff (!resetn)
      cmdAccess && overrun && stackRef |=> fault_q == 5'h0C && ret_q == $past(offs_q))
      else $error("stack overrun wrong");
   vecLimit_a: assert property (@(posedge clk) disable iff (!resetn)
      cmdInt && vecOut |=> faultValid_q && fault_q == 5'h08)
      else $error("vector limit fault missing");
   noFault_a: assert property (@(posedge clk) disable iff (!resetn)
      !faultValid_q || (fault_q != 5'h0A && fault_q != 5'h0B && fault_q != 5'h0E
      && fault_q != 5'h11))
      else $error("forbidden fault code");
   haltStay_a: assert property (@(posedge clk) disable iff (!resetn)
      haltTaken_s ##1 (haltHeld_s and !haltWake) |=> (haltHeld_s and !busActive))
      else $error("halt left without cause");
   wrapShut_a: assert property (@(posedge clk) disable iff (!resetn)
      stackWrap |=> state_q == sapu_pkg::SHUTDOWN && shutdownCycle)
      else $error("odd stack wrap missed");
   nmiExit_a: assert property (@(posedge clk) disable iff (!resetn)
      state_q == sapu_pkg::SHUTDOWN && nmiRise |=> (state_q == sapu_pkg::RUN) == $past(nmiOk))
      else $error("shutdown exit wrong");
   highBits_a: assert property (@(posedge clk) disable iff (!resetn)
      cmdAccess && !protMode && !highAddr_q |=> phys_q[31:21] == 11'h000)
      else $error("upper address still high");
   effPriv_a: assert property (@(posedge clk) disable iff (!resetn)
      effPriv >= reqPriv && effPriv >= accr_q[6:5])
      else $error("effective privilege low");
   paging_a: assert property (@(posedge clk) disable iff (!resetn)
      cmdAccess && protMode && !pageEn |=> phys_q == $past(linear))
      else $error("unpaged address altered");
endmodule
`default_nettype wire

/* test/sapu_core_tb_top.sv */
// Self-checking testbench of the address and privilege unit.
`timescale 1ns/1ps
`default_nettype none
`include "sapu_defs.svh"
module sapu_core_tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO;
   logic wbAck;
   logic nmiReq = 1'b0;
   logic irqReq = 1'b0;
   logic nmiPin;
   logic maskableIrq;
   logic busActive;
   logic shutdownCycle;
   logic [31:0] sdCount = 32'h0;
   int failCount = 0;
   int checkCount = 0;
   int cycles = 0;
   sapu_core i_sapu_core (.clk(clk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
      .wbAck(wbAck), .nmiPin(nmiPin), .maskableIrq(maskableIrq), .busActive(busActive),
      .shutdownCycle(shutdownCycle));
   sapu_irq_source i_sapu_irq_source (.clk(clk), .resetn(resetn), .nmiReq(nmiReq),
      .irqReq(irqReq), .nmiPin(nmiPin), .maskableIrq(maskableIrq));
   always #5 clk = ~clk;
   task automatic finalReport();
      if (failCount == 0 && checkCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // The whole sequence needs a few hundred cycles; the ceiling leaves wide margin.
   always @(posedge clk)
   begin
      cycles++;
      if (shutdownCycle === 1'b1)
         sdCount <= sdCount + 32'h1;
      if (cycles == 20000)
      begin
         failCount++;
         finalReport();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp)
      begin
         failCount++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic single cycle: the request stands until ack is sampled high.
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatI <= dat;
      wbSel <= 4'hF;
      do @(posedge clk); while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] unused;
      xfer(1'b1, adr, dat, unused);
   endtask
   task automatic rdc(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] rd;
      xfer(1'b0, adr, 32'h0, rd);
      check(rd & mask, exp);
   endtask
   task automatic waitBus(input logic exp);
      for (int i = 0; i < 40 && busActive !== exp; i++)
         @(posedge clk);
      check({31'h0, busActive}, {31'h0, exp});
   endtask
   task automatic nmi();
      @(posedge clk);
      nmiReq <= 1'b1;
      @(posedge clk);
      nmiReq <= 1'b0;
   endtask
   task automatic doReset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
   endtask
   initial
   begin
      doReset();
      rdc(`SAPU_OFF_STAT, 32'h13, 32'h10);
      rdc(`SAPU_OFF_TLIM, 32'hFFFF, 32'h3FF);
      rdc(8'h3C, 32'hFFFFFFFF, 32'h0);
      check({31'h0, busActive}, 32'h1);
      wr(`SAPU_OFF_SEG, 32'hFFFF);
      wr(`SAPU_OFF_OFFS, 32'hFFFF);
      wr(`SAPU_OFF_CMD, 32'h1);
      rdc(`SAPU_OFF_PHYS, 32'hFFFFFFFF, 32'h0010FFEF);
      wr(`SAPU_OFF_CMD, 32'h10001);
      rdc(`SAPU_OFF_STAT, 32'h3F03, 32'h2D00);
      rdc(`SAPU_OFF_RET, 32'hFFFFFFFF, 32'hFFFF);
      wr(`SAPU_OFF_CTRL, 32'h8);
      wr(`SAPU_OFF_CMD, 32'h10001);
      rdc(`SAPU_OFF_STAT, 32'h3F03, 32'h2C00);
      rdc(`SAPU_OFF_RET, 32'hFFFFFFFF, 32'hFFFF);
      wr(`SAPU_OFF_CTRL, 32'h10);
      wr(`SAPU_OFF_SEG, 32'h1000);
      wr(`SAPU_OFF_OFFS, 32'h10);
      wr(`SAPU_OFF_CMD, 32'h1);
      rdc(`SAPU_OFF_PHYS, 32'hFFFFFFFF, 32'hFFF10010);
      wr(`SAPU_OFF_CMD, 32'h4);
      wr(`SAPU_OFF_CMD, 32'h1);
      rdc(`SAPU_OFF_PHYS, 32'hFFFFFFFF, 32'h00010010);
      rdc(`SAPU_OFF_STAT, 32'h10, 32'h0);
      wr(`SAPU_OFF_CTRL, 32'h0);
      wr(`SAPU_OFF_CMD, 32'h2110);
      rdc(`SAPU_OFF_PHYS, 32'hFFFFFFFF, 32'h84);
      wr(`SAPU_OFF_TLIM, 32'h30);
      wr(`SAPU_OFF_CMD, 32'h1010);
      rdc(`SAPU_OFF_STAT, 32'h3F03, 32'h2800);
      wr(`SAPU_OFF_SP, 32'h6);
      wr(`SAPU_OFF_TLIM, 32'h20);
      wr(`SAPU_OFF_OFFS, 32'hFFFF);
      wr(`SAPU_OFF_CMD, 32'h10001);
      rdc(`SAPU_OFF_STAT, 32'h3, 32'h2);
      check(sdCount, 32'h1);
      waitBus(1'b0);
      nmi();
      waitBus(1'b1);
      wr(`SAPU_OFF_SP, 32'h1);
      wr(`SAPU_OFF_CMD, 32'h8);
      rdc(`SAPU_OFF_STAT, 32'h3, 32'h2);
      check(sdCount, 32'h2);
      nmi();
      repeat (20) @(posedge clk);
      check(sdCount, 32'h3);
      check({31'h0, busActive}, 32'h0);
      doReset();
      rdc(`SAPU_OFF_STAT, 32'h13, 32'h10);
      wr(`SAPU_OFF_OFFS, 32'h100);
      wr(`SAPU_OFF_CMD, 32'h2);
      waitBus(1'b0);
      rdc(`SAPU_OFF_RET, 32'hFFFFFFFF, 32'h101);
      irqReq <= 1'b1;
      repeat (15) @(posedge clk);
      check({31'h0, busActive}, 32'h0);
      wr(`SAPU_OFF_CTRL, 32'h4);
      waitBus(1'b1);
      irqReq <= 1'b0;
      wr(`SAPU_OFF_CTRL, 32'h0);
      wr(`SAPU_OFF_CMD, 32'h2);
      waitBus(1'b0);
      nmi();
      waitBus(1'b1);
      wr(`SAPU_OFF_TLIM, 32'h20);
      wr(`SAPU_OFF_SP, 32'h6);
      wr(`SAPU_OFF_CMD, 32'h3010);
      rdc(`SAPU_OFF_STAT, 32'h3, 32'h2);
      check(sdCount, 32'h4);
      nmi();
      waitBus(1'b1);
      wr(`SAPU_OFF_CTRL, 32'h1);
      wr(8'h48, 32'h12340000);
      wr(`SAPU_OFF_SEL, 32'h11);
      wr(`SAPU_OFF_ACCR, 32'h40);
      wr(`SAPU_OFF_OFFS, 32'h5678);
      wr(`SAPU_OFF_CS, 32'h3);
      wr(`SAPU_OFF_CMD, 32'h1);
      rdc(`SAPU_OFF_PHYS, 32'hFFFFFFFF, 32'h12345678);
      rdc(`SAPU_OFF_STAT, 32'hFF0000, 32'hB90000);
      wr(`SAPU_OFF_CTRL, 32'h21);
      wr(`SAPU_OFF_CS, 32'h0);
      rdc(`SAPU_OFF_STAT, 32'h300000, 32'h300000);
      wr(`SAPU_OFF_CTRL, 32'h3);
      wr(`SAPU_OFF_PFRM, 32'hABCDE);
      wr(`SAPU_OFF_CMD, 32'h1);
      rdc(`SAPU_OFF_PHYS, 32'hFFFFFFFF, 32'hABCDE678);
      wr(`SAPU_OFF_CTRL, 32'h2);
      wr(`SAPU_OFF_SEG, 32'h100);
      wr(`SAPU_OFF_OFFS, 32'h20);
      wr(`SAPU_OFF_CMD, 32'h1);
      rdc(`SAPU_OFF_PHYS, 32'hFFFFFFFF, 32'h1020);
      finalReport();
   end
endmodule
`default_nettype wire

/* test/sapu_irq_source.sv */
// Far-side model of the interrupt sources: a stretched non-maskable pulse and a level request.
`timescale 1ns/1ps
`default_nettype none
module sapu_irq_source (
   input wire logic clk,
   input wire logic resetn,
   input wire logic nmiReq,
   input wire logic irqReq,
   output logic nmiPin,
   output logic maskableIrq
);
   logic [2:0] pulseLeft_q;
   // The pulse is stretched to four cycles so that the input synchroniser cannot miss it.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pulseLeft_q <= 3'h0;
      end
      else if (nmiReq)
      begin
         pulseLeft_q <= 3'h4;
      end
      else if (pulseLeft_q != 3'h0)
      begin
         pulseLeft_q <= pulseLeft_q - 3'h1;
      end
   end
   assign nmiPin = (pulseLeft_q != 3'h0);
   assign maskableIrq = irqReq;
endmodule
`default_nettype wire
